// ### rtl/pcl_port_cfg.sv
// Port clock, loopback, alarm-pin select and pin polarity configuration with APB slave
//
// Overview of operation
// - Loop timing set: transmit clock from receive side, transmit clock pin ignored.
// - Adapter disable clear allows adapter clocks; set without loopback uses clock pin.
// - Receive framer timing select: 0 output clocks, 1 input clocks.
// - Transmit framer timing select: 0 output clocks, 1 input clocks.
// - Transmit line timing select: 0 output clocks, 1 input clocks.
// - Loopback code decodes to analog, line, payload, diagnostic or line plus diagnostic.
// - Loopback field resets to no loopback.
// - Bits 7:4 select second pin alarm, driven only when globally enabled.
// - Bits 3:0 select first pin alarm, driven only when globally enabled.
// - Alarm codes pick single alarms or documented combinations.
// - Transmit invert bits 12, 10, 5 flip frame-start out, serial data, frame-start in.
// - Transmit invert bits 9..6 flip overhead frame-start, enable, data, clock.
// - Transmit invert bits 4, 3, 2 flip negative rail, data, line clock.
// - Transmit invert bits 1, 0 flip clock output and clock input.
// - Receive invert bits 12, 10 flip frame-start out and serial data.
// - Receive invert bits 9, 7, 6 flip overhead frame-start, data, clock.
// - Receive invert bits 4..1 flip negative, positive, line clock, clock output.
module pcl_port_cfg (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [9:0]             paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   port_soft_reset,
  input  wire logic                   first_pin_global_en,
  input  wire logic                   second_pin_global_en,
  input  wire pcl_pkg::pcl_alarm_t    alarms,
  input  wire logic [12:0]            tx_pins_raw,
  input  wire logic [12:0]            rx_pins_raw,
  output logic                        first_general_pin,
  output logic                        second_general_pin,
  output pcl_pkg::pcl_loop_t          loop_paths,
  output pcl_pkg::pcl_clk_ctrl_t      clk_ctrl,
  output pcl_pkg::pcl_txsrc_t         tx_clock_source,
  output logic [12:0]                 tx_pins_adj,
  output logic [12:0]                 rx_pins_adj
);

  logic [15:0] clock_timing_q;
  logic [15:0] loop_alarm_q;
  logic [15:0] tx_polarity_q;
  logic [15:0] rx_polarity_q;
  logic [1:0]  gen1_sync_q;
  logic [1:0]  gen2_sync_q;
  logic [5:0]  alarm_meta_q;
  logic [5:0]  alarm_sync_q;
  logic [12:0] tx_meta_q;
  logic [12:0] tx_sync_q;
  logic [12:0] rx_meta_q;
  logic [12:0] rx_sync_q;
  logic        access;
  logic        wr_en;
  logic        hit;
  logic [7:0]  reg_idx;
  logic [15:0] wmask;
  logic [15:0] rdata_d;
  pcl_pkg::pcl_loop_t loop_d;
  logic        first_d;
  logic        second_d;

  // One wait state: every answer comes from a flop, a write lands on the pready edge
  assign access  = psel && penable;
  assign reg_idx = paddr[9:2];
  assign hit     = (paddr[1:0] == 2'h0) &&
                   (reg_idx == pcl_pkg::IDX_CLOCK_TIMING || reg_idx == pcl_pkg::IDX_LOOP_ALARM ||
                    reg_idx == pcl_pkg::IDX_TX_POLARITY  || reg_idx == pcl_pkg::IDX_RX_POLARITY);
  assign wr_en   = access && pwrite && hit && pready;
  assign wmask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Software reset acts like presetn on the configuration state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_timing_q <= pcl_pkg::RST_CLOCK_TIMING;
      loop_alarm_q   <= pcl_pkg::RST_LOOP_ALARM;
      tx_polarity_q  <= pcl_pkg::RST_TX_POLARITY;
      rx_polarity_q  <= pcl_pkg::RST_RX_POLARITY;
    end else if (port_soft_reset) begin
      clock_timing_q <= pcl_pkg::RST_CLOCK_TIMING;
      loop_alarm_q   <= pcl_pkg::RST_LOOP_ALARM;
      tx_polarity_q  <= pcl_pkg::RST_TX_POLARITY;
      rx_polarity_q  <= pcl_pkg::RST_RX_POLARITY;
    end else if (wr_en) begin
      // Reserved bits masked so they never store
      unique case (reg_idx)
        pcl_pkg::IDX_CLOCK_TIMING: clock_timing_q <= (clock_timing_q & ~wmask) |
                                     (pwdata[15:0] & wmask & pcl_pkg::MASK_CLOCK_TIMING);
        pcl_pkg::IDX_LOOP_ALARM:   loop_alarm_q <= (loop_alarm_q & ~wmask) |
                                     (pwdata[15:0] & wmask & pcl_pkg::MASK_LOOP_ALARM);
        pcl_pkg::IDX_TX_POLARITY:  tx_polarity_q <= (tx_polarity_q & ~wmask) |
                                     (pwdata[15:0] & wmask & pcl_pkg::MASK_TX_POLARITY);
        pcl_pkg::IDX_RX_POLARITY:  rx_polarity_q <= (rx_polarity_q & ~wmask) |
                                     (pwdata[15:0] & wmask & pcl_pkg::MASK_RX_POLARITY);
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_d = 16'h0000;
    if (reg_idx == pcl_pkg::IDX_CLOCK_TIMING) begin
      rdata_d = clock_timing_q;
    end else if (reg_idx == pcl_pkg::IDX_LOOP_ALARM) begin
      rdata_d = loop_alarm_q;
    end else if (reg_idx == pcl_pkg::IDX_TX_POLARITY) begin
      rdata_d = tx_polarity_q;
    end else if (reg_idx == pcl_pkg::IDX_RX_POLARITY) begin
      rdata_d = rx_polarity_q;
    end
  end

  // Answer launched in the first access cycle, held for exactly the pready cycle
  // Error flags unmapped or misaligned addresses; registers untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !hit;
      prdata  <= (access && !pready && !pwrite && hit) ? {16'h0000, rdata_d} :
                 32'h0000_0000;
    end
  end

  // Pins and globally owned enables come from outside the pclk domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen1_sync_q  <= 2'h0;
      gen2_sync_q  <= 2'h0;
      alarm_meta_q <= 6'h00;
      alarm_sync_q <= 6'h00;
      tx_meta_q    <= 13'h0000;
      tx_sync_q    <= 13'h0000;
      rx_meta_q    <= 13'h0000;
      rx_sync_q    <= 13'h0000;
    end else begin
      gen1_sync_q  <= {gen1_sync_q[0], first_pin_global_en};
      gen2_sync_q  <= {gen2_sync_q[0], second_pin_global_en};
      alarm_meta_q <= alarms;
      alarm_sync_q <= alarm_meta_q;
      tx_meta_q    <= tx_pins_raw;
      tx_sync_q    <= tx_meta_q;
      rx_meta_q    <= rx_pins_raw;
      rx_sync_q    <= rx_meta_q;
    end
  end

  // Loopback decode
  always_comb begin
    loop_d = '0;
    unique case (loop_alarm_q[pcl_pkg::POS_LOOPBACK_LO +: 3])
      pcl_pkg::LB_NONE:    loop_d = '0;
      pcl_pkg::LB_ANALOG:  loop_d.analog_loopback = 1'b1;
      pcl_pkg::LB_LINE:    loop_d.line_loopback = 1'b1;
      pcl_pkg::LB_PAYLOAD: loop_d.payload_loopback = 1'b1;
      pcl_pkg::LB_DIAG_A,
      pcl_pkg::LB_DIAG_B,
      pcl_pkg::LB_DIAG_C:  loop_d.diagnostic_loopback = 1'b1;
      pcl_pkg::LB_LINE_DG: begin
        loop_d.line_loopback = 1'b1;
        loop_d.diagnostic_loopback = 1'b1;
      end
    endcase
  end

  function automatic logic alarm_pick(input logic [3:0] code, input pcl_pkg::pcl_alarm_t a);
    logic r;
    r = 1'b0;
    unique case (code)
      pcl_pkg::AL_LOS:     r = a.line_loss_of_signal;
      pcl_pkg::AL_OOF:     r = a.out_of_frame_alarm;
      pcl_pkg::AL_LOF:     r = a.loss_of_frame_alarm;
      pcl_pkg::AL_AIS:     r = a.alarm_indication;
      pcl_pkg::AL_RAI:     r = a.remote_alarm_indication;
      pcl_pkg::AL_IDLE:    r = a.idle;
      pcl_pkg::AL_COMBO_A,
      pcl_pkg::AL_COMBO_B: r = a.line_loss_of_signal | a.loss_of_frame_alarm |
                               a.alarm_indication;
      pcl_pkg::AL_RAI_IDL: r = a.remote_alarm_indication | a.idle;
      pcl_pkg::AL_ALL:     r = |a;
      default:             r = 1'b0;
    endcase
    return r;
  endfunction : alarm_pick

  assign first_d  = gen1_sync_q[1] &&
                    alarm_pick(loop_alarm_q[pcl_pkg::POS_FIRST_SEL_LO +: 4], alarm_sync_q);
  assign second_d = gen2_sync_q[1] &&
                    alarm_pick(loop_alarm_q[pcl_pkg::POS_SECOND_SEL_LO +: 4], alarm_sync_q);

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_general_pin  <= 1'b0;
      second_general_pin <= 1'b0;
      loop_paths         <= '0;
      clk_ctrl           <= '0;
      tx_clock_source    <= pcl_pkg::PCL_TXSRC_ADAPTER;
    end else begin
      first_general_pin  <= first_d;
      second_general_pin <= second_d;
      loop_paths         <= loop_d;
      clk_ctrl.loop_timing_enable      <= clock_timing_q[pcl_pkg::POS_LOOP_TIMING];
      clk_ctrl.adapter_clock_disable   <= clock_timing_q[pcl_pkg::POS_ADAPTER_DIS];
      clk_ctrl.rx_framer_timing_select <= clock_timing_q[pcl_pkg::POS_RX_FRAMER_TS];
      clk_ctrl.tx_framer_timing_select <= clock_timing_q[pcl_pkg::POS_TX_FRAMER_TS];
      clk_ctrl.tx_line_timing_select   <= clock_timing_q[pcl_pkg::POS_TX_LINE_TS];
      // Loop timing has priority; adapter disable falls back to pin only without loopback
      if (clock_timing_q[pcl_pkg::POS_LOOP_TIMING]) begin
        tx_clock_source <= pcl_pkg::PCL_TXSRC_RECEIVE;
      end else if (clock_timing_q[pcl_pkg::POS_ADAPTER_DIS] && (loop_d == '0)) begin
        tx_clock_source <= pcl_pkg::PCL_TXSRC_PIN;
      end else begin
        tx_clock_source <= pcl_pkg::PCL_TXSRC_ADAPTER;
      end
    end
  end

  // Pin polarity: one XOR per pin, masks keep unnamed bits from flipping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pins_adj <= 13'h0000;
      rx_pins_adj <= 13'h0000;
    end else begin
      tx_pins_adj <= tx_sync_q ^
                     (tx_polarity_q[12:0] & pcl_pkg::MASK_TX_POLARITY[12:0]);
      rx_pins_adj <= rx_sync_q ^
                     (rx_polarity_q[12:0] & pcl_pkg::MASK_RX_POLARITY[12:0]);
    end
  end

  // Assertions
  chk_loop_reset_none: assert property (@(posedge pclk)
    $rose(presetn) |-> loop_paths == '0) else $error("loopback not clear after reset");

  chk_loop_line_diag: assert property (@(posedge pclk) disable iff (!presetn)
    loop_alarm_q[10:8] == pcl_pkg::LB_LINE_DG |=> loop_paths.line_loopback &&
      loop_paths.diagnostic_loopback && !loop_paths.analog_loopback)
    else $error("line plus diagnostic decode wrong");

  chk_loop_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    loop_alarm_q[10:8] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7} |=> $onehot(loop_paths))
    else $error("single loopback decode not one-hot");

  chk_loop_timing_src: assert property (@(posedge pclk) disable iff (!presetn)
    clock_timing_q[4] |=> tx_clock_source == pcl_pkg::PCL_TXSRC_RECEIVE)
    else $error("loop timing did not select receive clock");

  chk_adapter_pin_src: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_timing_q[4] && clock_timing_q[3] && loop_alarm_q[10:8] == 3'h0
      |=> tx_clock_source == pcl_pkg::PCL_TXSRC_PIN)
    else $error("adapter disable did not select clock pin");

  chk_first_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !gen1_sync_q[1] |=> !first_general_pin) else $error("first pin driven while disabled");

  chk_second_pin_idle: assert property (@(posedge pclk) disable iff (!presetn)
    loop_alarm_q[7:4] inside {4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC} |=> !second_general_pin)
    else $error("unassigned code drove second pin");

  chk_first_all_alarms: assert property (@(posedge pclk) disable iff (!presetn)
    gen1_sync_q[1] && loop_alarm_q[3:0] == 4'hF && |alarm_sync_q |=> first_general_pin)
    else $error("all-alarm code missed an alarm");

  chk_tx_invert: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> tx_pins_adj[12] == ($past(tx_sync_q[12]) ^ $past(tx_polarity_q[12])))
    else $error("transmit frame-start output polarity wrong");

  chk_rx_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> rx_pins_adj[0] == $past(rx_sync_q[0])) else $error("reserved invert bit acted");

  chk_apb_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && reg_idx == pcl_pkg::IDX_CLOCK_TIMING |-> prdata[31:5] == '0)
    else $error("reserved bits read non-zero");

  chk_timing_selects: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> clk_ctrl[2:0] == $past(clock_timing_q[2:0]))
    else $error("timing reference selects not passed on");

  chk_adapter_src: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_timing_q[4] && !clock_timing_q[3]
      |=> tx_clock_source == pcl_pkg::PCL_TXSRC_ADAPTER)
    else $error("adapter clock not used while allowed");

  chk_second_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !gen2_sync_q[1] |=> !second_general_pin) else $error("second pin driven while disabled");

  chk_first_pin_idle: assert property (@(posedge pclk) disable iff (!presetn)
    loop_alarm_q[3:0] inside {4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC} |=> !first_general_pin)
    else $error("unassigned code drove first pin");

  chk_second_rai_idle: assert property (@(posedge pclk) disable iff (!presetn)
    gen2_sync_q[1] && loop_alarm_q[7:4] == 4'hE
      |=> second_general_pin == ($past(alarm_sync_q[4]) || $past(alarm_sync_q[5])))
    else $error("remote alarm or idle combination wrong");

  chk_tx_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> tx_pins_adj[10:0] == ($past(tx_sync_q[10:0]) ^ $past(tx_polarity_q[10:0])))
    else $error("transmit pin polarity wrong");

  chk_rx_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> rx_pins_adj[12:1] == ($past(rx_sync_q[12:1]) ^ $past(rx_polarity_q[12:1])))
    else $error("receive pin polarity wrong");

  cov_line_diag: cover property (@(posedge pclk) disable iff (!presetn)
    loop_paths.line_loopback && loop_paths.diagnostic_loopback);
  cov_loop_timing: cover property (@(posedge pclk) disable iff (!presetn)
    tx_clock_source == pcl_pkg::PCL_TXSRC_RECEIVE);
  cov_second_pin: cover property (@(posedge pclk) disable iff (!presetn) second_general_pin);
  cov_write_then_read: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en ##[1:4] (access && !pwrite && hit));

endmodule : pcl_port_cfg

// ### inc/pcl_pkg.sv
// Register map, field positions and types of the port clock/loopback/pin-polarity block
package pcl_pkg;

  // Printed offsets are not all multiples of four: they are register indices
  localparam logic [7:0] IDX_CLOCK_TIMING = 8'h44;
  localparam logic [7:0] IDX_LOOP_ALARM   = 8'h46;
  localparam logic [7:0] IDX_TX_POLARITY  = 8'h4A;
  localparam logic [7:0] IDX_RX_POLARITY  = 8'h4C;
  localparam int unsigned ADDR_W = 10;

  // Writable bit masks; every other bit reads zero
  localparam logic [15:0] MASK_CLOCK_TIMING = 16'h001F;
  localparam logic [15:0] MASK_LOOP_ALARM   = 16'h07FF;
  localparam logic [15:0] MASK_TX_POLARITY  = 16'h17FF;
  localparam logic [15:0] MASK_RX_POLARITY  = 16'h16DE;

  localparam logic [15:0] RST_CLOCK_TIMING = 16'h0000;
  localparam logic [15:0] RST_LOOP_ALARM   = 16'h0000;
  localparam logic [15:0] RST_TX_POLARITY  = 16'h0000;
  localparam logic [15:0] RST_RX_POLARITY  = 16'h0000;

  // Clock/timing control field positions
  localparam int unsigned POS_LOOP_TIMING   = 4;
  localparam int unsigned POS_ADAPTER_DIS   = 3;
  localparam int unsigned POS_RX_FRAMER_TS  = 2;
  localparam int unsigned POS_TX_FRAMER_TS  = 1;
  localparam int unsigned POS_TX_LINE_TS    = 0;

  // Loopback/alarm field positions
  localparam int unsigned POS_LOOPBACK_LO   = 8;
  localparam int unsigned POS_SECOND_SEL_LO = 4;
  localparam int unsigned POS_FIRST_SEL_LO  = 0;

  // Transmit polarity bits
  localparam int unsigned POS_TX_FS_OUT   = 12;
  localparam int unsigned POS_TX_SER      = 10;
  localparam int unsigned POS_TX_OH_FS    = 9;
  localparam int unsigned POS_TX_OH_EN    = 8;
  localparam int unsigned POS_TX_OH_DAT   = 7;
  localparam int unsigned POS_TX_OH_CLK   = 6;
  localparam int unsigned POS_TX_FS_IN    = 5;
  localparam int unsigned POS_TX_NEG      = 4;
  localparam int unsigned POS_TX_DAT      = 3;
  localparam int unsigned POS_TX_LCLK     = 2;
  localparam int unsigned POS_TX_CLKO     = 1;
  localparam int unsigned POS_TX_CLKI     = 0;

  // Receive polarity bits
  localparam int unsigned POS_RX_FS_OUT   = 12;
  localparam int unsigned POS_RX_SER      = 10;
  localparam int unsigned POS_RX_OH_FS    = 9;
  localparam int unsigned POS_RX_OH_DAT   = 7;
  localparam int unsigned POS_RX_OH_CLK   = 6;
  localparam int unsigned POS_RX_NEG      = 4;
  localparam int unsigned POS_RX_POS      = 3;
  localparam int unsigned POS_RX_LCLK     = 2;
  localparam int unsigned POS_RX_CLKO     = 1;

  // Loopback codes
  localparam logic [2:0] LB_NONE    = 3'h0;
  localparam logic [2:0] LB_ANALOG  = 3'h1;
  localparam logic [2:0] LB_LINE    = 3'h2;
  localparam logic [2:0] LB_PAYLOAD = 3'h3;
  localparam logic [2:0] LB_DIAG_A  = 3'h4;
  localparam logic [2:0] LB_DIAG_B  = 3'h5;
  localparam logic [2:0] LB_LINE_DG = 3'h6;
  localparam logic [2:0] LB_DIAG_C  = 3'h7;

  // Alarm select codes
  localparam logic [3:0] AL_LOS     = 4'h0;
  localparam logic [3:0] AL_OOF     = 4'h1;
  localparam logic [3:0] AL_LOF     = 4'h2;
  localparam logic [3:0] AL_AIS     = 4'h3;
  localparam logic [3:0] AL_RAI     = 4'h4;
  localparam logic [3:0] AL_IDLE    = 4'h5;
  localparam logic [3:0] AL_COMBO_A = 4'hB;
  localparam logic [3:0] AL_COMBO_B = 4'hD;
  localparam logic [3:0] AL_RAI_IDL = 4'hE;
  localparam logic [3:0] AL_ALL     = 4'hF;

  // Alarm inputs, one bit each
  typedef struct packed {
    logic idle;
    logic remote_alarm_indication;
    logic alarm_indication;
    logic loss_of_frame_alarm;
    logic out_of_frame_alarm;
    logic line_loss_of_signal;
  } pcl_alarm_t;

  // Decoded loopback paths
  typedef struct packed {
    logic analog_loopback;
    logic line_loopback;
    logic payload_loopback;
    logic diagnostic_loopback;
  } pcl_loop_t;

  // Timing-reference and clock-source controls
  typedef struct packed {
    logic loop_timing_enable;
    logic adapter_clock_disable;
    logic rx_framer_timing_select;
    logic tx_framer_timing_select;
    logic tx_line_timing_select;
  } pcl_clk_ctrl_t;

  // Transmit clock source chosen from the controls
  typedef enum logic [1:0] {
    PCL_TXSRC_ADAPTER,
    PCL_TXSRC_PIN,
    PCL_TXSRC_RECEIVE
  } pcl_txsrc_t;

endpackage : pcl_pkg

// ### tb/testbench.sv
// Self-checking bench for the port clock, loopback, alarm-pin and polarity block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [9:0]             paddr;
  logic [31:0]            pwdata, prdata, rd, rnd;
  logic [3:0]             pstrb;
  logic                   port_soft_reset, first_pin_global_en, second_pin_global_en, err;
  logic                   first_general_pin, second_general_pin;
  pcl_pkg::pcl_alarm_t    alarms;
  pcl_pkg::pcl_loop_t     loop_paths;
  pcl_pkg::pcl_clk_ctrl_t clk_ctrl;
  pcl_pkg::pcl_txsrc_t    tx_clock_source, src_e;
  logic [12:0]            tx_pins_raw, rx_pins_raw, tx_pins_adj, rx_pins_adj;
  logic [15:0]            m [4];
  logic [15:0]            msk [4];
  logic [9:0]             adr [4];
  int                     failures, tests_run;

  pcl_port_cfg dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .port_soft_reset(port_soft_reset),
    .first_pin_global_en(first_pin_global_en), .second_pin_global_en(second_pin_global_en),
    .alarms(alarms), .tx_pins_raw(tx_pins_raw), .rx_pins_raw(rx_pins_raw),
    .first_general_pin(first_general_pin), .second_general_pin(second_general_pin),
    .loop_paths(loop_paths), .clk_ctrl(clk_ctrl), .tx_clock_source(tx_clock_source),
    .tx_pins_adj(tx_pins_adj), .rx_pins_adj(rx_pins_adj));

  always #20 pclk = ~pclk;

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until pready is sampled; never assumes the wait-state count
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Model update per byte lane, reserved bits dropped
  task automatic wr_reg(input int i, input logic [15:0] d, input logic [1:0] s);
    apb(1'b1, adr[i], {16'hA5A5, d}, {2'b11, s});
    for (int b = 0; b < 2; b++)
      if (s[b]) m[i][8*b+:8] = d[8*b+:8] & msk[i][8*b+:8];
  endtask : wr_reg

  task automatic settle;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  function automatic logic al_exp(input logic [3:0] c, input pcl_pkg::pcl_alarm_t a);
    case (c)
      4'h0: return a.line_loss_of_signal;
      4'h1: return a.out_of_frame_alarm;
      4'h2: return a.loss_of_frame_alarm;
      4'h3: return a.alarm_indication;
      4'h4: return a.remote_alarm_indication;
      4'h5: return a.idle;
      4'hB, 4'hD: return a.line_loss_of_signal | a.loss_of_frame_alarm | a.alarm_indication;
      4'hE: return a.remote_alarm_indication | a.idle;
      4'hF: return |a;
      default: return 1'b0;
    endcase
  endfunction : al_exp

  function automatic logic [3:0] lb_exp(input logic [2:0] c);
    case (c)
      3'h0: return 4'h0;
      3'h1: return 4'h8;
      3'h2: return 4'h4;
      3'h3: return 4'h2;
      3'h6: return 4'h5;
      default: return 4'h1;
    endcase
  endfunction : lb_exp

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    give_verdict();
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 10'h000; pwdata = 32'h0; pstrb = 4'h0; port_soft_reset = 1'b0;
    first_pin_global_en = 1'b0; second_pin_global_en = 1'b0; alarms = '0;
    tx_pins_raw = 13'h0000; rx_pins_raw = 13'h0000;
    failures = 0; tests_run = 0;
    adr = '{{pcl_pkg::IDX_CLOCK_TIMING, 2'b00}, {pcl_pkg::IDX_LOOP_ALARM, 2'b00},
            {pcl_pkg::IDX_TX_POLARITY, 2'b00}, {pcl_pkg::IDX_RX_POLARITY, 2'b00}};
    msk = '{pcl_pkg::MASK_CLOCK_TIMING, pcl_pkg::MASK_LOOP_ALARM,
            pcl_pkg::MASK_TX_POLARITY, pcl_pkg::MASK_RX_POLARITY};
    m = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    void'($urandom(32'h95E193D1));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, adr[i], 32'h0, 4'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 10'h3FC, 32'hFFFF, 4'hF);
    chk(err, 1'b1);
    apb(1'b1, adr[1] | 10'h001, 32'h07FF, 4'hF);
    chk(err, 1'b1);
    apb(1'b0, adr[1], 32'h0, 4'h0);
    chk(rd, 32'h0);
    repeat (16) begin
      rnd = $urandom;
      wr_reg(rnd[3:2], $urandom, rnd[1:0]);
      apb(1'b0, adr[rnd[3:2]], 32'h0, 4'h0);
      chk(rd, {16'h0, m[rnd[3:2]]});
      chk(err, 1'b0);
    end
    for (int l = 0; l < 8; l++) begin
      wr_reg(1, {5'h00, l[2:0], 8'h00}, 2'b11);
      for (int c = 0; c < 32; c++) begin
        wr_reg(0, {11'h000, c[4:0]}, 2'b01);
        settle();
        src_e = c[4] ? pcl_pkg::PCL_TXSRC_RECEIVE :
                (c[3] && l == 0) ? pcl_pkg::PCL_TXSRC_PIN : pcl_pkg::PCL_TXSRC_ADAPTER;
        chk(loop_paths, lb_exp(l[2:0]));
        chk(clk_ctrl, c[4:0]);
        chk(tx_clock_source, src_e);
      end
    end
    for (int c = 0; c < 64; c++) begin
      rnd = $urandom;
      alarms <= rnd[5:0];
      first_pin_global_en <= c[4];
      second_pin_global_en <= c[5];
      wr_reg(1, {8'h00, c[3:0], ~c[3:0]}, 2'b01);
      settle();
      chk(second_general_pin, c[5] & al_exp(c[3:0], alarms));
      chk(first_general_pin, c[4] & al_exp(~c[3:0], alarms));
    end
    repeat (12) begin
      wr_reg(2, $urandom, 2'b11);
      wr_reg(3, $urandom, 2'b11);
      tx_pins_raw <= $urandom;
      rx_pins_raw <= $urandom;
      settle();
      chk(tx_pins_adj, tx_pins_raw ^ m[2][12:0]);
      chk(rx_pins_adj, rx_pins_raw ^ m[3][12:0]);
    end
    // Soft reset in mid-run must clear every register, the loopback paths and the clock source
    wr_reg(1, 16'h06FF, 2'b11);
    @(posedge pclk);
    port_soft_reset <= 1'b1;
    @(posedge pclk);
    port_soft_reset <= 1'b0;
    settle();
    chk(loop_paths, 4'h0);
    chk(tx_clock_source, pcl_pkg::PCL_TXSRC_ADAPTER);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, adr[i], 32'h0, 4'h0);
      chk(rd, 32'h0);
    end
    // Hardware reset in mid-run, with a loopback mode pending
    wr_reg(1, 16'h0700, 2'b11);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, adr[1], 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(loop_paths, 4'h0);
    give_verdict();
  end
endmodule : testbench
